// [inc/serial_memory_master_pkg.sv]
// constants and types shared by the serial memory master and its two-wire engine
// How it works
// RQ1: only one link format, four-wire or two-wire, runs at any time.
// RQ2: four-wire link offers two separate chip selects on shared clock and data.
// RQ3: chip select active level is selectable high or low.
// RQ4: four-wire clock idle level and sampling phase are selectable, four combinations.
// RQ5: four-wire clock is programmable from 101.96 kHz to 26 MHz.
// RQ6: four-wire bit order is selectable, most or least significant first.
// RQ7: a four-wire access sends command bits, then address bits, select held.
// RQ8: the memory answers a read by shifting out bytes from the address.
// RQ9: during a read, select stays asserted until all bytes arrived, then drops.
// RQ10: during a program, select stays asserted until all write bytes are sent.
// RQ11: command code and address width are configurable to suit the memory.
// RQ12: a codec target takes an 8-bit header first, then one or more bytes.
// RQ13: two-wire link is clock master only, standard 100 kHz or fast 400 kHz.
// RQ14: two-wire drivers are selectable as open-drain or push-pull.
// RQ15: two-wire targets use 7-bit addresses only.
// RQ16: two-wire transfer opens with START, target address and direction, byte address.
// RQ17: every two-wire byte is shifted most significant bit first.
// RQ18: on two-wire reads the master acknowledges each byte and refuses the last.
// RQ19: on two-wire writes the master samples the target acknowledge after every byte.
// RQ20: multi-byte two-wire transfers run without breaks; STOP only after the last byte.
// RQ21: a refused address or write byte ends the transfer with STOP and an error.
// RQ22: two-wire clock comes from a divider that never exceeds the chosen rate.
package serial_memory_master_pkg;

  localparam int MCLK_HZ = 200_000_000;
  localparam int SPI_FMAX_HZ = 26_000_000;
  // lowest four-wire rate in units of 10 Hz (101.96 kHz)
  localparam int SPI_FMIN_10HZ = 10196;
  localparam int I2C_STD_HZ = 100_000;
  localparam int I2C_FAST_HZ = 400_000;

  localparam int SPI_HALF_W = 10;
  localparam int I2C_Q_W = 12;
  localparam logic [SPI_HALF_W-1:0] SPI_HALF_MIN =
    SPI_HALF_W'((MCLK_HZ + 2 * SPI_FMAX_HZ - 1) / (2 * SPI_FMAX_HZ));
  localparam logic [SPI_HALF_W-1:0] SPI_HALF_MAX = SPI_HALF_W'(MCLK_HZ / (20 * SPI_FMIN_10HZ));
  localparam logic [I2C_Q_W-1:0] I2C_Q_STD = I2C_Q_W'((MCLK_HZ + 4 * I2C_STD_HZ - 1) / (4 * I2C_STD_HZ));
  localparam logic [I2C_Q_W-1:0] I2C_Q_FAST = I2C_Q_W'((MCLK_HZ + 4 * I2C_FAST_HZ - 1) / (4 * I2C_FAST_HZ));

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] CS_RESET = 2'h3;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [1:0] {S_IDLE = 2'b00, S_SHIFT = 2'b01, S_TRAIL = 2'b11} spi_state_type;
  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_START = 3'b001, I_BITS = 3'b011, I_STOP = 3'b010, I_RSTART = 3'b110
  } i2c_state_type;
  typedef enum logic [1:0] {STG_DEVW = 2'h0, STG_MEM = 2'h1, STG_DEVR = 2'h3, STG_DATA = 2'h2} i2c_stage_type;

endpackage : serial_memory_master_pkg

// [design/twowire_master.sv]
// two-wire bus master engine: start, addressing, data bytes, acknowledge, stop
module twowire_master
  import serial_memory_master_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic go,
  input wire logic is_write,
  input wire logic fast,
  input wire logic opendrain,
  input wire logic [7:0] extra,
  input wire logic [6:0] dev_addr,
  input wire logic [7:0] mem_addr,
  input wire logic [CNT_W-1:0] byte_count,
  // data
  input wire logic [7:0] tx_data,
  output logic tx_take,
  output logic [7:0] rx_data,
  output logic rx_valid,
  // status
  output logic busy,
  output logic done,
  output logic nack,
  // line, sda_in already synchronised
  input wire logic sda_in,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe
);

  i2c_state_type state;
  i2c_stage_type stage;
  logic [1:0] q;
  logic [I2C_Q_W-1:0] qc;
  logic [I2C_Q_W-1:0] quarter;
  logic [3:0] bitn;
  logic [7:0] sh;
  logic [CNT_W-1:0] left;
  logic rd_byte, fail, scl_lvl, sda_lvl, sda_drv, tick;

  // stretch only lengthens the quarter period, so the chosen rate is never exceeded
  assign quarter = (fast ? I2C_Q_FAST : I2C_Q_STD) + {4'h0, extra}; // see RQ13 RQ22
  assign tick = (qc == '0);
  assign busy = (state != I_IDLE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) qc <= '0;
    else if (!busy || tick) qc <= busy ? quarter - 1'b1 : '0;
    else qc <= qc - 1'b1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= I_IDLE;
      stage <= STG_DEVW;
      q <= 2'h0;
      bitn <= 4'h0;
      sh <= 8'h00;
      left <= '0;
      rd_byte <= 1'b0;
      fail <= 1'b0;
      scl_lvl <= 1'b1;
      sda_lvl <= 1'b1;
      sda_drv <= 1'b1;
      tx_take <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      rx_valid <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      case (state)
        I_IDLE: if (go) begin
          state <= I_START;
          q <= 2'h0;
          stage <= STG_DEVW;
          rd_byte <= 1'b0;
          fail <= 1'b0;
          sh <= {dev_addr, 1'b0}; // see RQ15 RQ16
          left <= (byte_count == '0) ? CNT_W'(1) : byte_count;
        end
        I_START: if (tick) begin
          q <= q + 2'h1;
          case (q)
            2'h0: begin
              scl_lvl <= 1'b1;
              sda_lvl <= 1'b1;
              sda_drv <= 1'b1;
            end
            2'h1: sda_lvl <= 1'b0; // see RQ16
            default: begin
              scl_lvl <= 1'b0;
              state <= I_BITS;
              q <= 2'h0;
              bitn <= 4'h0;
            end
          endcase
        end
        I_RSTART: if (tick) begin
          q <= 2'h1;
          if (q == 2'h0) begin
            scl_lvl <= 1'b0;
            sda_lvl <= 1'b1;
            sda_drv <= 1'b1;
          end else begin
            scl_lvl <= 1'b1;
            state <= I_START;
          end
        end
        I_BITS: if (tick) begin
          q <= q + 2'h1;
          case (q)
            2'h0: begin
              scl_lvl <= 1'b0;
              if (bitn < BYTE_BITS) begin
                sda_drv <= !rd_byte;
                sda_lvl <= rd_byte | sh[7]; // see RQ17
              end else if (rd_byte) begin
                sda_drv <= 1'b1;
                sda_lvl <= (left == CNT_W'(1)); // see RQ18
              end else begin
                sda_drv <= 1'b0;
                sda_lvl <= 1'b1;
              end
            end
            2'h1: scl_lvl <= 1'b1;
            2'h2: begin
              if (bitn < BYTE_BITS) begin
                if (rd_byte) sh <= {sh[6:0], sda_in};
              end else if (!rd_byte) begin
                fail <= sda_in; // see RQ19
              end
            end
            default: begin
              scl_lvl <= 1'b0;
              if (bitn < BYTE_BITS) begin
                bitn <= bitn + 4'h1;
                if (!rd_byte) sh <= {sh[6:0], 1'b0};
              end else begin
                bitn <= 4'h0;
                if (fail) begin
                  state <= I_STOP; // see RQ21
                  nack <= 1'b1;
                end else begin
                  case (stage)
                    STG_DEVW: begin
                      stage <= STG_MEM;
                      sh <= mem_addr; // see RQ16
                    end
                    STG_MEM: begin
                      if (is_write) begin
                        stage <= STG_DATA;
                        sh <= tx_data;
                        tx_take <= 1'b1;
                      end else begin
                        state <= I_RSTART;
                        stage <= STG_DEVR;
                        sh <= {dev_addr, 1'b1};
                      end
                    end
                    STG_DEVR: begin
                      stage <= STG_DATA;
                      rd_byte <= 1'b1;
                    end
                    default: begin
                      if (rd_byte) begin
                        rx_data <= sh;
                        rx_valid <= 1'b1;
                      end
                      left <= left - CNT_W'(1);
                      if (left == CNT_W'(1)) begin
                        state <= I_STOP; // see RQ20
                      end else if (!rd_byte) begin
                        sh <= tx_data;
                        tx_take <= 1'b1;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
        I_STOP: if (tick) begin
          q <= q + 2'h1;
          case (q)
            2'h0: begin
              scl_lvl <= 1'b0;
              sda_lvl <= 1'b0;
              sda_drv <= 1'b1;
            end
            2'h1: scl_lvl <= 1'b1;
            2'h2: sda_lvl <= 1'b1; // see RQ20
            default: begin
              state <= I_IDLE;
              done <= 1'b1;
            end
          endcase
        end
        default: state <= I_IDLE;
      endcase
    end
  end

  // open-drain only ever pulls low; push-pull drives both levels
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o <= opendrain ? 1'b0 : scl_lvl; // see RQ14
      scl_oe <= opendrain ? !scl_lvl : 1'b1;
      sda_o <= opendrain ? 1'b0 : sda_lvl;
      sda_oe <= sda_drv & (opendrain ? !sda_lvl : 1'b1);
    end
  end

endmodule : twowire_master

// [design/serial_memory_master.sv]
// serial memory port master: four-wire engine, format selection and shared status
module serial_memory_master
  import serial_memory_master_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // transfer control
  input wire logic start,
  input wire logic use_twowire,
  input wire logic is_write,
  input wire logic [CNT_W-1:0] byte_count,
  output logic busy,
  output logic done,
  output logic error,
  input wire logic error_clear,
  // data
  input wire logic [7:0] tx_data,
  output logic tx_take,
  output logic [7:0] rx_data,
  output logic rx_valid,
  // four-wire setup
  input wire logic cs_sel,
  input wire logic cs_active_high,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb_first,
  input wire logic [SPI_HALF_W-1:0] sck_half,
  input wire logic [7:0] cmd_code,
  input wire logic [3:0] cmd_bits,
  input wire logic [23:0] mem_address,
  input wire logic [4:0] addr_bits,
  // two-wire setup
  input wire logic [6:0] dev_addr,
  input wire logic [7:0] byte_addr,
  input wire logic fast_rate,
  input wire logic open_drain,
  input wire logic [7:0] scl_stretch,
  // four-wire pins
  output logic sck,
  output logic mosi,
  input wire logic miso,
  output logic [1:0] cs,
  // two-wire pins
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  input wire logic sda_i
);

  // the 12-bit bit counter must hold header plus eight bits per byte
  if (CNT_W < 1 || CNT_W > 8) begin : g_bad_cnt_w
    $error("CNT_W must lie between 1 and 8");
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // pin synchronisers, stage 0 feeds stage 1 only
  logic [1:0] miso_sync, sda_sync;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      miso_sync <= SYNC_RESET;
      sda_sync <= SYNC_RESET;
    end else begin
      miso_sync <= {miso_sync[0], miso};
      sda_sync <= {sda_sync[0], sda_i};
    end
  end

  // format selection and shared status
  logic spi_go, i2c_go, i2c_busy, i2c_done, i2c_nack, i2c_take, i2c_rx_valid;
  logic spi_done, spi_take, spi_rx_valid, twowire_active;
  logic [7:0] i2c_rx, spi_rx;
  spi_state_type spi_state;

  assign busy = (spi_state != S_IDLE) | i2c_busy;
  assign spi_go = start & !busy & !use_twowire; // see RQ1
  assign i2c_go = start & !busy & use_twowire; // see RQ1
  assign done = spi_done | i2c_done;
  assign tx_take = spi_take | i2c_take;
  assign rx_valid = spi_rx_valid | i2c_rx_valid;
  assign rx_data = twowire_active ? i2c_rx : spi_rx;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) twowire_active <= 1'b0;
    else if (start && !busy) twowire_active <= use_twowire;
  end

  // a refusal arriving with the clear still sets the flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) error <= 1'b0;
    else if (i2c_nack) error <= 1'b1; // see RQ21
    else if (error_clear) error <= 1'b0;
  end

  twowire_master #(
    .CNT_W(CNT_W)
  ) u_twowire (
    .mclk(mclk),
    .rst(rst),
    .go(i2c_go),
    .is_write(is_write),
    .fast(fast_rate),
    .opendrain(open_drain),
    .extra(scl_stretch),
    .dev_addr(dev_addr),
    .mem_addr(byte_addr),
    .byte_count(byte_count),
    .tx_data(tx_data),
    .tx_take(i2c_take),
    .rx_data(i2c_rx),
    .rx_valid(i2c_rx_valid),
    .busy(i2c_busy),
    .done(i2c_done),
    .nack(i2c_nack),
    .sda_in(sda_sync[1]),
    .scl_o(scl_o),
    .scl_oe(scl_oe),
    .sda_o(sda_o),
    .sda_oe(sda_oe)
  );

  // four-wire engine
  logic [SPI_HALF_W-1:0] half_eff, hc;
  logic [CNT_W-1:0] byte_count_eff;
  logic [11:0] idx, nbits, hlen, drive_idx, data_pos;
  logic [7:0] txb, rxsh, rx_next;
  logic h, edge_ev, samp_ev, drive_ev, load_ev;

  assign half_eff = (sck_half < SPI_HALF_MIN) ? SPI_HALF_MIN :
                    (sck_half > SPI_HALF_MAX) ? SPI_HALF_MAX : sck_half; // see RQ5
  assign byte_count_eff = (byte_count == '0) ? CNT_W'(1) : byte_count;
  assign hlen = {8'h00, cmd_bits} + {7'h00, addr_bits}; // see RQ11 RQ12
  assign nbits = hlen + 12'({byte_count_eff, 3'h0});
  assign edge_ev = (spi_state == S_SHIFT) && (hc == '0);
  assign samp_ev = edge_ev && (h == cpha); // see RQ4
  assign drive_ev = edge_ev && (h != cpha) && (drive_idx < nbits);
  assign drive_idx = cpha ? idx : idx + 12'h001;
  assign data_pos = idx - hlen;
  assign rx_next = lsb_first ? {miso_sync[1], rxsh[7:1]} : {rxsh[6:0], miso_sync[1]}; // see RQ6
  assign load_ev = (spi_go && !cpha && is_load(12'h000)) || (drive_ev && is_load(drive_idx));

  // value of transfer bit k: command, then address, then write data
  function automatic logic out_bit(input logic [11:0] k);
    logic [11:0] j;
    logic [2:0] b;
    j = 12'h000;
    b = 3'h0;
    if (k < {8'h00, cmd_bits}) begin
      j = lsb_first ? k : {8'h00, cmd_bits} - 12'h001 - k;
      out_bit = cmd_code[j[2:0]];
    end else if (k < hlen) begin
      j = k - {8'h00, cmd_bits};
      j = lsb_first ? j : {7'h00, addr_bits} - 12'h001 - j;
      out_bit = mem_address[j[4:0]];
    end else if (is_write) begin
      j = k - hlen;
      b = lsb_first ? j[2:0] : 3'h7 - j[2:0];
      out_bit = (j[2:0] == 3'h0) ? tx_data[b] : txb[b];
    end else begin
      out_bit = 1'b0;
    end
  endfunction : out_bit

  // first bit of a write byte takes a new byte from the user side
  function automatic logic is_load(input logic [11:0] k);
    logic [11:0] j;
    j = k - hlen;
    is_load = is_write && (k >= hlen) && (j[2:0] == 3'h0);
  endfunction : is_load

  // sequencing and bit counting
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      spi_state <= S_IDLE;
      hc <= '0;
      h <= 1'b0;
      idx <= 12'h000;
      spi_done <= 1'b0;
    end else begin
      spi_done <= 1'b0;
      case (spi_state)
        S_IDLE: if (spi_go) begin
          spi_state <= S_SHIFT;
          hc <= half_eff - 1'b1;
          h <= 1'b0;
          idx <= 12'h000;
        end
        S_SHIFT: begin
          if (hc != '0) begin
            hc <= hc - 1'b1;
          end else begin
            hc <= half_eff - 1'b1;
            h <= !h;
            if (h) begin
              idx <= idx + 12'h001;
              if (idx + 12'h001 == nbits) spi_state <= S_TRAIL; // see RQ9 RQ10
            end
          end
        end
        S_TRAIL: begin
          if (hc != '0) begin
            hc <= hc - 1'b1;
          end else begin
            spi_state <= S_IDLE;
            spi_done <= 1'b1;
          end
        end
        default: spi_state <= S_IDLE;
      endcase
    end
  end

  // clock, data out and chip selects
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck <= 1'b0;
      mosi <= 1'b0;
      cs <= CS_RESET;
    end else begin
      if (spi_state == S_IDLE) sck <= cpol; // see RQ4
      else if (edge_ev) sck <= h ? cpol : !cpol;
      if (spi_go && !cpha) mosi <= out_bit(12'h000); // see RQ7
      else if (drive_ev) mosi <= out_bit(drive_idx); // see RQ7 RQ6
      for (int i = 0; i < 2; i++) begin
        cs[i] <= ((spi_state != S_IDLE) && (cs_sel == 1'(i))) == cs_active_high; // see RQ2 RQ3 RQ9
      end
    end
  end

  // write bytes taken and read bytes assembled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txb <= 8'h00;
      spi_take <= 1'b0;
      rxsh <= 8'h00;
      spi_rx <= 8'h00;
      spi_rx_valid <= 1'b0;
    end else begin
      spi_take <= load_ev; // see RQ10
      spi_rx_valid <= 1'b0;
      if (load_ev) txb <= tx_data;
      if (samp_ev && !is_write && idx >= hlen) begin
        rxsh <= rx_next;
        if (data_pos[2:0] == 3'h7) begin
          spi_rx <= rx_next; // see RQ9
          spi_rx_valid <= 1'b1;
        end
      end
    end
  end

  // checks
  logic cs0_on, cs1_on, scl_line, sda_line, first_cmd_bit;
  logic [CNT_W:0] chk_bytes;

  assign cs0_on = (cs[0] == cs_active_high);
  assign cs1_on = (cs[1] == cs_active_high);
  assign scl_line = scl_oe ? scl_o : 1'b1;
  assign sda_line = sda_oe ? sda_o : 1'b1;
  assign first_cmd_bit = lsb_first ? cmd_code[0] : cmd_code[3'(cmd_bits - 4'h1)];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) chk_bytes <= '0;
    else if (spi_go) chk_bytes <= '0;
    else if (spi_take || spi_rx_valid) chk_bytes <= chk_bytes + 1'b1;
  end

  property p_one_format;
    !((spi_state != S_IDLE) && i2c_busy);
  endproperty
  a_one_format: assert property (p_one_format) else $error("both link formats active"); // see RQ1

  // a polarity change reaches the registered selects one cycle late
  property p_cs_single;
    $stable(cs_active_high) |-> !(cs0_on && cs1_on);
  endproperty
  a_cs_single: assert property (p_cs_single) else $error("both chip selects asserted"); // see RQ2

  property p_cs_idle;
    (spi_state == S_IDLE) && $past(spi_state == S_IDLE) && $stable(cs_active_high) |-> !cs0_on && !cs1_on;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("chip select asserted while idle"); // see RQ3

  property p_sck_idle;
    (spi_state == S_IDLE) && $past(spi_state == S_IDLE) && $stable(cpol) |-> sck == cpol;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("serial clock not at idle level"); // see RQ4

  property p_sck_rate;
    $changed(sck) && (spi_state != S_IDLE) |=> !$changed(sck) [*3];
  endproperty
  a_sck_rate: assert property (p_sck_rate) else $error("serial clock half period too short"); // see RQ5

  property p_cs_hold;
    (spi_state == S_SHIFT) && $past(spi_state == S_SHIFT) |-> (cs_sel ? cs1_on : cs0_on);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("chip select dropped mid transfer"); // see RQ9 RQ10

  property p_spi_count;
    spi_done |-> chk_bytes == {1'b0, byte_count_eff};
  endproperty
  a_spi_count: assert property (p_spi_count) else $error("wrong number of bytes moved"); // see RQ9 RQ10

  property p_first_bit;
    spi_go && !cpha && (cmd_bits != 4'h0) |=> mosi == $past(first_cmd_bit);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("transfer did not open with command"); // see RQ7 RQ6

  property p_i2c_start;
    $rose(i2c_busy) |-> ##[1:1000] (scl_line && !sda_line);
  endproperty
  a_i2c_start: assert property (p_i2c_start) else $error("no start condition seen"); // see RQ16

  property p_i2c_stop;
    i2c_done |-> scl_line && sda_line && $past(sda_line, 1);
  endproperty
  a_i2c_stop: assert property (p_i2c_stop) else $error("bus not released at end"); // see RQ20

  property p_open_drain;
    open_drain && $past(open_drain) |-> !(sda_oe && sda_o) && !(scl_oe && scl_o);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain line driven high"); // see RQ14

  property p_nack_error;
    i2c_nack |=> error;
  endproperty
  a_nack_error: assert property (p_nack_error) else $error("refusal did not set error"); // see RQ21

  c_spi_read: cover property (spi_done && !is_write && byte_count_eff > CNT_W'(1));
  c_spi_write: cover property (spi_done && is_write);
  c_i2c_read: cover property (i2c_done && !is_write && !error);
  c_i2c_nack: cover property (i2c_nack);

endmodule : serial_memory_master

// [testbench/serial_memory_model.sv]
// partner model: four-wire memory data source and two-wire memory target
module serial_memory_model #(
  parameter logic [7:0] PAT = 8'h5A
) (
  // clock
  input wire logic mclk,
  // four-wire side
  input wire logic sck,
  input wire logic sel,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [4:0] hdr_bits,
  output logic miso,
  // two-wire side
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  output logic pull
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  int bits = 0;
  int bytes = 0;
  logic idle = 1'b0;
  logic rd = 1'b0;
  logic quiet = 1'b0;
  initial pull = 1'b0;
  always @(posedge mclk) idle <= ~idle;
  // shift on the edge opposite the sampling one so data is settled when sampled
  always @(posedge sck or negedge sck or negedge sel) cnt = !sel ? 0 : (sck == (cpol ^ cpha)) ? cnt + 1 : cnt;
  assign miso = (sel && cnt - int'(cpha) >= int'(hdr_bits)) ? PAT[7 - (cnt - int'(cpha)) % 8] : idle;
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bits = 0;
      bytes = 0;
      rd = 1'b0;
      quiet = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (bits == 7 && bytes == 0) rd = sda;
    if (bits == 8 && rd && bytes > 0 && sda) quiet = 1'b1;
    if (bits == 8) bytes++;
    bits = (bits == 8) ? 0 : bits + 1;
  end
  // acknowledge written bytes, present read data msb first
  always @(negedge scl) begin
    pull <= (bits == 8) ? (ack_en && !(rd && bytes > 0)) : (rd && bytes > 0 && !quiet && !PAT[7 - bits]);
  end
endmodule : serial_memory_model

// [testbench/test_serial_memory_master.sv]
// self-checking bench for the serial memory master
module test_serial_memory_master;
  import serial_memory_master_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MEM_BYTE = 8'h5A;
  logic mclk = 1'b0, rst = 1'b1, start = 1'b0, use_twowire = 1'b0, is_write = 1'b0, error_clear = 1'b0;
  logic cs_sel = 1'b0, cs_active_high = 1'b0, lsb_first = 1'b0, open_drain = 1'b0, ack_en = 1'b1;
  logic cpol = 1'b0, cpha = 1'b0;
  logic [7:0] byte_count = 8'h01, tx_data = 8'h00, cmd_code = 8'h00, byte_addr = 8'h00;
  logic [23:0] mem_address = 24'h000000;
  logic [6:0] dev_addr = 7'h50;
  logic [4:0] addr_bits = 5'h08;
  logic [SPI_HALF_W-1:0] sck_half = 10'h004;
  logic busy, done, error, tx_take, rx_valid, sck, mosi, miso, scl_o, scl_oe, sda_o, sda_oe, pull;
  logic [7:0] rx_data;
  logic [1:0] cs;
  logic [15:0] cap, exp;
  logic [7:0] rxq[$];
  int error_cnt = 0, checks_done = 0, takes = 0, nb = 0, starts = 0, cyc = 0;
  wire scl = scl_oe ? scl_o : 1'b1;
  wire sda = (sda_oe ? sda_o : 1'b1) & ~pull;
  wire sel = cs[cs_sel] == cs_active_high;

  always #2.5 mclk = ~mclk;

  serial_memory_master i_dut (.mclk(mclk), .rst(rst), .start(start), .use_twowire(use_twowire),
    .is_write(is_write), .byte_count(byte_count), .busy(busy), .done(done), .error(error),
    .error_clear(error_clear), .tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid),
    .cs_sel(cs_sel), .cs_active_high(cs_active_high), .cpol(cpol), .cpha(cpha), .lsb_first(lsb_first),
    .sck_half(sck_half), .cmd_code(cmd_code), .cmd_bits(4'h8), .mem_address(mem_address),
    .addr_bits(addr_bits), .dev_addr(dev_addr), .byte_addr(byte_addr), .fast_rate(1'b1),
    .open_drain(open_drain), .scl_stretch(8'h00), .sck(sck), .mosi(mosi), .miso(miso), .cs(cs),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .sda_i(sda));

  serial_memory_model #(.PAT(MEM_BYTE)) i_mem (.mclk(mclk), .sck(sck), .sel(sel), .cpol(cpol), .cpha(cpha),
    .hdr_bits(5'(8 + addr_bits)), .miso(miso), .scl(scl), .sda(sda), .ack_en(ack_en), .pull(pull));

  // wire monitors
  // capture on the sampling edge, where the master never changes mosi
  always @(posedge sck or negedge sck) if (busy && nb < 16 && sck == !(cpol ^ cpha)) begin
    cap = {cap[14:0], mosi};
    nb++;
  end
  always @(negedge mclk) begin
    if (tx_take === 1'b1) takes++;
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
  end
  always @(negedge sda) if (scl === 1'b1) starts++;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      end_of_test();
    end
  end

  function automatic logic [7:0] ord(input logic [7:0] v, input logic lsb);
    return lsb ? {<<{v}} : v;
  endfunction : ord

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic run(input logic two, input logic wr, input int n);
    cap = 16'h0000;
    nb = 0;
    takes = 0;
    starts = 0;
    rxq.delete();
    use_twowire = two;
    is_write = wr;
    byte_count = 8'(n);
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    repeat (2) @(negedge mclk);
    if (!two) check(16'(cs), 16'({cs_active_high ? 2'b01 << cs_sel : ~(2'b01 << cs_sel)}));
    while (done !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    check(16'(cs), 16'({2{~cs_active_high}}));
  endtask : run

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  initial begin
    void'($urandom(32'h69EC6899));
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 6; i++) begin
      cs_sel = i[0];
      cs_active_high = i[1];
      lsb_first = 1'($urandom);
      cmd_code = 8'($urandom);
      mem_address = 24'($urandom);
      tx_data = 8'($urandom);
      addr_bits = i[2] ? 5'h00 : 5'h08;
      sck_half = 10'(4 + $urandom_range(3));
      {cpol, cpha} = 2'($urandom);
      // let the idle clock level settle before the request
      @(negedge mclk);
      run(1'b0, i[0] ^ i[1], 1 + $urandom_range(2));
      exp[15:8] = ord(cmd_code, lsb_first);
      exp[7:0] = addr_bits != 0 ? ord(mem_address[7:0], lsb_first) : is_write ? ord(tx_data, lsb_first) : 8'h00;
      check(cap, exp);
      check(16'(is_write ? takes : rxq.size()), 16'(byte_count));
      foreach (rxq[k]) check(16'(rxq[k]), 16'(ord(MEM_BYTE, lsb_first)));
    end
    dev_addr = 7'($urandom);
    byte_addr = 8'($urandom);
    open_drain = 1'($urandom);
    run(1'b1, 1'b1, 2);
    check(16'(error), 16'h0000);
    check(16'(starts), 16'h0001);
    check(16'(takes), 16'h0002);
    run(1'b1, 1'b0, 3);
    check(16'(starts), 16'h0002);
    check(16'(rxq.size()), 16'h0003);
    foreach (rxq[k]) check(16'(rxq[k]), 16'(MEM_BYTE));
    ack_en = 1'b0;
    run(1'b1, 1'b1, 2);
    check(16'(error), 16'h0001);
    error_clear = 1'b1;
    @(negedge mclk);
    error_clear = 1'b0;
    @(negedge mclk);
    check(16'(error), 16'h0000);
    end_of_test();
  end
endmodule : test_serial_memory_master
